// File: include/ptm_pkg.sv
// package: constants and mode codes for the period timer mode logic
package ptm_pkg;
	localparam int          CNT_W           = 8;
	localparam int          MODE_W          = 5;
	localparam logic [7:0]  PERIOD_RST      = 8'hff;
	localparam logic [7:0]  COUNT_RST       = 8'h00;
	// mode codes handled by this block
	localparam logic [4:0]  MODE_LVL_LO     = 5'h06;
	localparam logic [4:0]  MODE_LVL_HI     = 5'h07;
	localparam logic [4:0]  MODE_SW_ONESHOT = 5'h08;
	localparam logic [4:0]  MODE_OS_RISE    = 5'h09;
	localparam logic [4:0]  MODE_OS_FALL    = 5'h0a;
	localparam logic [4:0]  MODE_OS_ANY     = 5'h0b;
	localparam logic [4:0]  MODE_HL_RISE    = 5'h0c;
	localparam logic [4:0]  MODE_HL_FALL    = 5'h0d;
	localparam logic [4:0]  MODE_LR_LO      = 5'h0e;
	localparam logic [4:0]  MODE_LR_HI      = 5'h0f;
	// count clocks between reset assert/release and its effect
	localparam logic [1:0]  RST_DELAY       = 2'h2;
	localparam int          SYNC_STAGES     = 2;
endpackage : ptm_pkg

// File: src/ptm_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module ptm_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	if (WIDTH < 1)
	begin : g_bad_width
		$error("ptm_sync: WIDTH must be positive");
	end

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ptm_sync_t;

	ptm_sync_t st_ff;
	ptm_sync_t nxt_st;

	always_comb
	begin
		nxt_st    = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign q = st_ff.s2;
endmodule : ptm_sync
`default_nettype wire

// File: src/ptm_timer.sv
// period timer mode logic: limit, one-shot and pwm drive control
// Function
// - Levels 00110/00111 reset counter while external input low / high respectively.
// - Level limit modes ignore the external input while run bit clear.
// - Level limit: reset on period match or two clocks after reset asserts.
// - Level limit: resume after match, or two clocks after reset released.
// - Level limit: pwm high at count start, low on duty match, held through reset.
// - Mode 01000: period match resets counter and clears run bit.
// - Mode 01000: clearing run mid-cycle pauses, setting again continues.
// - Mode 01000: drive starts with run set, ends at duty match, stretched by pause.
// - Mode 01000: new cycle only after run bit set again; drive off meanwhile.
// - Modes 01001-01011 start on rise/fall/any edge with run set; match clears run.
// - Edge one-shot: after run cleared, a fresh edge is needed to resume.
// - Edge one-shot: start edge activates drive; duty match ends it; stays off.
// - Modes 01100/01101: first edge starts, later edges reset, resume two clocks later.
// - Edge limit one-shot: match resets and clears run; edges ignored until set.
// - Edge limit one-shot: start and reset edges activate drive; duty match ends it.
// - Modes 01110/01111 hold reset at reset level; start on transition to active.
// - Level reset one-shot: match clears run; new transition needed after re-set.
// - Level reset one-shot: drive on at start edge, off at duty match, also forced off at wrap.
// - At count equal to period, counter returns to zero next clock unless halted.
// - Run bit and external input are synchronised with two count-clock flops.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer #(
	parameter int CNT_W = ptm_pkg::CNT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic [4:0]       mode_sel,
	input  wire logic             run_set,
	input  wire logic             run_in,
	input  wire logic             ext_reset_trigger_in,
	input  wire logic [CNT_W-1:0] period_value,
	input  wire logic [CNT_W-1:0] duty_compare_value,
	output logic      [CNT_W-1:0] count_value,
	output logic      [CNT_W-1:0] period_out,
	output logic                  run_state,
	output logic                  run_clear_pulse,
	output logic                  pwm_drive,
	output logic                  period_match_out,
	output logic                  mode_supported
);
	// ====================================================================
	// elaboration checks
	if (CNT_W < 2 || CNT_W > 16)
	begin : g_bad_cnt_w
		$error("ptm_timer: CNT_W out of range");
	end

	// ====================================================================
	// reset release and input synchronisation
	logic [1:0] rst_sync_ff;
	logic       rst_n_int;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n_int = rst_sync_ff[1];

	logic [1:0] sync_q;
	logic       run_sw;
	logic       ext_s;

	// two-flop sync of run and ext input
	ptm_sync #(
		.WIDTH(2)
	) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n_int),
		.ce    (clk_en),
		.d     ({run_in, ext_reset_trigger_in}),
		.q     (sync_q)
	);
	assign run_sw = sync_q[1];
	assign ext_s  = sync_q[0];

	// ====================================================================
	// mode classification
	typedef enum logic [4:0] {
		PTM_IDLE  = 5'h01,
		PTM_ARMED = 5'h02,
		PTM_COUNT = 5'h04,
		PTM_HOLD  = 5'h08,
		PTM_DONE  = 5'h10
	} ptm_state_t;

	typedef struct packed {
		ptm_state_t       state;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] per;
		logic             ext_prev;
		logic             run_prev;
		logic             run;
		logic             run_clr;
		logic [1:0]       dly;
		logic             pwm;
		logic             match;
		logic             sup;
	} ptm_regs_t;

	ptm_regs_t r_ff;
	ptm_regs_t nxt_r;

	function automatic logic in_range(input logic [4:0] m, input logic [4:0] lo, input logic [4:0] hi);
		in_range = (m >= lo) && (m <= hi);
	endfunction : in_range

	logic is_lvl;
	logic is_sw;
	logic is_os;
	logic is_hl;
	logic is_lr;
	logic rise;
	logic fall;
	logic start_edge;
	logic rst_level;
	logic pmatch;
	logic dmatch;

	assign is_lvl = in_range(mode_sel, ptm_pkg::MODE_LVL_LO, ptm_pkg::MODE_LVL_HI);
	assign is_sw  = (mode_sel == ptm_pkg::MODE_SW_ONESHOT);
	assign is_os  = in_range(mode_sel, ptm_pkg::MODE_OS_RISE, ptm_pkg::MODE_OS_ANY);
	assign is_hl  = in_range(mode_sel, ptm_pkg::MODE_HL_RISE, ptm_pkg::MODE_HL_FALL);
	assign is_lr  = in_range(mode_sel, ptm_pkg::MODE_LR_LO, ptm_pkg::MODE_LR_HI);

	// edges from synced input vs one clock earlier
	assign rise = ext_s && !r_ff.ext_prev;
	assign fall = !ext_s && r_ff.ext_prev;

	// low-bit of the mode code picks polarity in each pair
	always_comb
	begin
		start_edge = 1'b0;
		rst_level  = 1'b0;
		case (mode_sel)
			ptm_pkg::MODE_OS_RISE,
			ptm_pkg::MODE_HL_RISE,
			ptm_pkg::MODE_LR_LO: start_edge = rise;
			ptm_pkg::MODE_OS_FALL,
			ptm_pkg::MODE_HL_FALL,
			ptm_pkg::MODE_LR_HI: start_edge = fall;
			ptm_pkg::MODE_OS_ANY: start_edge = rise || fall;
			default: start_edge = 1'b0;
		endcase
		case (mode_sel)
			ptm_pkg::MODE_LVL_LO,
			ptm_pkg::MODE_LR_LO: rst_level = !ext_s;
			ptm_pkg::MODE_LVL_HI,
			ptm_pkg::MODE_LR_HI: rst_level = ext_s;
			default: rst_level = 1'b0;
		endcase
	end

	// matches use the same cycle's count and period
	assign pmatch = (r_ff.cnt == r_ff.per);
	assign dmatch = (r_ff.cnt == duty_compare_value);

	// ====================================================================
	// next-state logic
	always_comb
	begin
		nxt_r          = r_ff;
		nxt_r.ext_prev = ext_s;
		nxt_r.run_prev = run_sw;
		nxt_r.per      = period_value;
		nxt_r.run_clr  = 1'b0;
		nxt_r.match    = 1'b0;
		nxt_r.sup      = is_lvl || is_sw || is_os || is_hl || is_lr;
		// a set pulse wins over any clear arriving in the same cycle
		if (run_sw && !r_ff.run_prev && !run_set)
			nxt_r.run = 1'b1;
		if (!run_sw)
			nxt_r.run = 1'b0;
		if (run_set)
			nxt_r.run = 1'b1;

		if (is_lvl)
		begin
			// input ignored while run bit clear
			if (!r_ff.run)
			begin
				nxt_r.state = PTM_IDLE;
				nxt_r.dly   = 2'h0;
			end
			else if (rst_level)
			begin
				// reset two clocks after reset asserts
				if (r_ff.dly != ptm_pkg::RST_DELAY)
					nxt_r.dly = r_ff.dly + 2'h1;
				else
				begin
					nxt_r.cnt   = '0;
					nxt_r.state = PTM_HOLD;
				end
				if (r_ff.state == PTM_HOLD)
					nxt_r.dly = ptm_pkg::RST_DELAY;
			end
			else if (r_ff.state == PTM_HOLD)
			begin
				if (r_ff.dly != 2'h0)
					nxt_r.dly = r_ff.dly - 2'h1;
				else
				begin
					nxt_r.state = PTM_COUNT;
					nxt_r.pwm   = 1'b1;
				end
			end
			else
			begin
				nxt_r.dly = 2'h0;
				if (r_ff.state == PTM_IDLE)
				begin
					nxt_r.state = PTM_COUNT;
					nxt_r.pwm   = 1'b1;
				end
				else if (pmatch)
				begin
					nxt_r.cnt   = '0;
					nxt_r.match = 1'b1;
					nxt_r.pwm   = 1'b1;
				end
				else
				begin
					nxt_r.cnt = r_ff.cnt + 1'b1;
					// low on duty match only while counting
					if (dmatch)
						nxt_r.pwm = 1'b0;
				end
			end
		end
		else if (is_sw)
		begin
			// paused count keeps value and drive
			if (r_ff.run)
			begin
				if (r_ff.state != PTM_COUNT)
					nxt_r.pwm = 1'b1;
				nxt_r.state = PTM_COUNT;
				if (pmatch && r_ff.state == PTM_COUNT)
				begin
					nxt_r.cnt     = '0;
					nxt_r.run     = run_set;
					nxt_r.run_clr = !run_set;
					nxt_r.match   = 1'b1;
					nxt_r.state   = PTM_DONE;
					nxt_r.pwm     = 1'b0;
				end
				else if (r_ff.state == PTM_COUNT)
				begin
					nxt_r.cnt = r_ff.cnt + 1'b1;
					if (dmatch)
						nxt_r.pwm = 1'b0;
				end
			end
			else if (r_ff.state == PTM_DONE)
				// drive stays off until run set again
				nxt_r.pwm = 1'b0;
		end
		else if (is_os || is_hl || is_lr)
		begin
			if (!r_ff.run)
			begin
				nxt_r.state = PTM_ARMED;
				if (is_hl || is_lr)
					nxt_r.cnt = '0;
				nxt_r.dly = 2'h0;
				if (r_ff.state != PTM_COUNT)
					nxt_r.pwm = 1'b0;
			end
			else if (is_lr && rst_level)
			begin
				nxt_r.cnt = '0;
				if (r_ff.state == PTM_COUNT)
					nxt_r.state = PTM_ARMED;
			end
			else if (r_ff.state == PTM_ARMED || r_ff.state == PTM_IDLE)
			begin
				if (start_edge)
				begin
					nxt_r.state = PTM_COUNT;
					nxt_r.pwm   = 1'b1;
				end
			end
			else if (r_ff.state == PTM_HOLD)
			begin
				// resume two clocks after a reset edge
				if (r_ff.dly != 2'h0)
					nxt_r.dly = r_ff.dly - 2'h1;
				else
					nxt_r.state = PTM_COUNT;
			end
			else if (is_hl && start_edge)
			begin
				nxt_r.cnt   = '0;
				nxt_r.state = PTM_HOLD;
				nxt_r.dly   = ptm_pkg::RST_DELAY - 2'h1;
				nxt_r.pwm   = 1'b1;
			end
			else if (r_ff.state == PTM_COUNT)
			begin
				if (pmatch)
				begin
					nxt_r.cnt     = '0;
					nxt_r.run     = run_set;
					nxt_r.run_clr = !run_set;
					nxt_r.match   = 1'b1;
					nxt_r.state   = PTM_DONE;
					nxt_r.pwm     = 1'b0;
				end
				else
				begin
					nxt_r.cnt = r_ff.cnt + 1'b1;
					if (dmatch)
						nxt_r.pwm = 1'b0;
				end
			end
			else
				nxt_r.state = PTM_ARMED;
		end
		else
		begin
			// unlisted modes leave the block inert
			nxt_r.state = PTM_IDLE;
			nxt_r.pwm   = 1'b0;
			nxt_r.dly   = 2'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			r_ff       <= '0;
			r_ff.state <= PTM_IDLE;
			r_ff.per   <= CNT_W'(ptm_pkg::PERIOD_RST);
			r_ff.cnt   <= CNT_W'(ptm_pkg::COUNT_RST);
		end
		else if (clk_en)
			r_ff <= nxt_r;
	end

	// ====================================================================
	// outputs, all registered
	assign count_value      = r_ff.cnt;
	assign period_out       = r_ff.per;
	assign run_state        = r_ff.run;
	assign run_clear_pulse  = r_ff.run_clr;
	assign pwm_drive        = r_ff.pwm;
	assign period_match_out = r_ff.match;
	assign mode_supported   = r_ff.sup;

	// ====================================================================
	// assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n_int);

	sequence s_os_match;
		clk_en && (is_sw || is_os || is_hl || is_lr) && r_ff.run && !run_set
			&& r_ff.state == PTM_COUNT && pmatch && !(is_lr && rst_level)
			&& !(is_hl && start_edge);
	endsequence

	a_oneshot_run_clear: assert property (s_os_match |=> !r_ff.run && r_ff.cnt == '0)
		else $error("one-shot match did not clear run and count");
	a_oneshot_drive_off: assert property (s_os_match |=> !r_ff.pwm)
		else $error("drive active after one-shot wrap");
	a_lvl_ignore_off: assert property (clk_en && is_lvl && !r_ff.run |=> r_ff.state == PTM_IDLE)
		else $error("level mode acted while run clear");
	a_sw_pause_hold: assert property (clk_en && is_sw && !r_ff.run && !run_set && $stable(mode_sel)
		|=> $stable(r_ff.cnt))
		else $error("software one-shot count moved while paused");
	a_wrap_zero: assert property (clk_en && is_lvl && r_ff.run && !rst_level && r_ff.state == PTM_COUNT
		&& pmatch |=> r_ff.cnt == '0 && r_ff.match)
		else $error("no wrap to zero on period match");
	a_lr_hold_reset: assert property (clk_en && is_lr && r_ff.run && rst_level |=> r_ff.cnt == '0)
		else $error("level reset not held");
	a_inert_mode: assert property (clk_en && !(is_lvl || is_sw || is_os || is_hl || is_lr)
		|=> !r_ff.pwm)
		else $error("drive active in unhandled mode");
	a_edge_start: assert property (clk_en && is_os && r_ff.run && r_ff.state == PTM_ARMED && start_edge
		|=> r_ff.state == PTM_COUNT && r_ff.pwm)
		else $error("edge did not start one-shot");
endmodule : ptm_timer
`default_nettype wire

// File: bench/ptm_ext_src.sv
// partner model: external reset/trigger source, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module ptm_ext_src (
	input  wire logic ref_clk,
	input  wire logic slow,
	input  wire logic want_level,
	output logic      ext_reset_trigger_in
);
	logic [1:0] lag_ff;

	initial lag_ff = 2'h0;
	initial ext_reset_trigger_in = 1'b0;

	// slow source lags each new level by two extra edges, like a distant driver
	always @(posedge ref_clk)
	begin
		lag_ff <= {lag_ff[0], want_level};
		ext_reset_trigger_in <= #1 (slow ? lag_ff[1] : want_level);
	end
endmodule : ptm_ext_src
`default_nettype wire

// File: bench/testbench.sv
// self-checking testbench for the period timer mode logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       ref_clk = 1'b0;
	logic       rst_n;
	logic       clk_en;
	logic [4:0] mode_sel;
	logic       run_set;
	logic       run_in;
	logic       ext_want;
	logic       slow;
	logic       ext;
	logic [7:0] period_value;
	logic [7:0] duty;
	logic [7:0] count_value;
	logic [7:0] period_out;
	logic       run_state;
	logic       run_clear_pulse;
	logic       pwm_drive;
	logic       period_match_out;
	logic       mode_supported;
	logic       pwm_seen;
	logic       idle;
	logic [7:0] c;
	int         n_mismatch = 0;
	int         num_checks = 0;

	always #2 ref_clk = ~ref_clk;

	ptm_ext_src src (.ref_clk(ref_clk), .slow(slow), .want_level(ext_want), .ext_reset_trigger_in(ext));

	ptm_timer dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .mode_sel(mode_sel), .run_set(run_set),
		.run_in(run_in), .ext_reset_trigger_in(ext), .period_value(period_value),
		.duty_compare_value(duty), .count_value(count_value), .period_out(period_out),
		.run_state(run_state), .run_clear_pulse(run_clear_pulse), .pwm_drive(pwm_drive),
		.period_match_out(period_match_out), .mode_supported(mode_supported)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic stop_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// bounded wait for a period wrap or for a given count
	task automatic wait_ev(input logic use_pm, input logic [7:0] v);
		int i;
		pwm_seen = 1'b0;
		for (i = 0; i < 600; i++)
		begin
			if (use_pm ? period_match_out === 1'b1 : count_value === v)
				break;
			pwm_seen |= (pwm_drive === 1'b1);
			tick(1);
		end
		if (i == 600)
		begin
			n_mismatch++;
			stop_test();
		end
	endtask : wait_ev

	// run off long enough that a later run rise is a fresh set
	task automatic prep(input logic [4:0] m, input logic lvl);
		run_in = 1'b0;
		ext_want = lvl;
		mode_sel = m;
		tick(6);
	endtask : prep

	task automatic match_done();
		wait_ev(1'b1, 8'h00);
		check("pwm seen", {7'h0, pwm_seen}, 8'h01);
		check("run cleared", {7'h0, run_state}, 8'h00);
		check("count wrapped", count_value, 8'h00);
		tick(1);
		check("pwm off at wrap", {7'h0, pwm_drive}, 8'h00);
		check("match pulse ended", {7'h0, period_match_out}, 8'h00);
	endtask : match_done

	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		run_set = 1'b0;
		run_in = 1'b0;
		ext_want = 1'b0;
		slow = 1'b0;
		mode_sel = ptm_pkg::MODE_SW_ONESHOT;
		period_value = 8'h05;
		duty = 8'h03;
		tick(8);
		rst_n = 1'b1;
		tick(4);
		// software one-shot: full cycle then stays idle
		run_in = 1'b1;
		wait_ev(1'b1, 8'h00);
		check("sw pwm seen", {7'h0, pwm_seen}, 8'h01);
		check("sw clear pulse", {7'h0, run_clear_pulse}, 8'h01);
		check("sw run", {7'h0, run_state}, 8'h00);
		tick(10);
		check("sw idle count", count_value, 8'h00);
		check("sw idle pwm", {7'h0, pwm_drive}, 8'h00);
		// restart by the set pulse, pause mid-cycle, then finish
		period_value = 8'h0c;
		duty = 8'h08;
		run_set = 1'b1;
		tick(1);
		run_set = 1'b0;
		wait_ev(1'b0, 8'h02);
		// a low enable must freeze the count mid-cycle
		clk_en = 1'b0;
		c = count_value;
		tick(4);
		check("frozen by enable", count_value, c);
		clk_en = 1'b1;
		run_in = 1'b0;
		tick(5);
		c = count_value;
		tick(6);
		check("sw paused", count_value, c);
		check("sw paused nonzero", {7'h0, c != 8'h00}, 8'h01);
		check("sw pwm stretched", {7'h0, pwm_drive}, 8'h01);
		run_in = 1'b1;
		wait_ev(1'b1, 8'h00);
		check("sw resumed", {7'h0, run_state}, 8'h00);
		// level-triggered limit modes, reset low then reset high
		for (int k = 0; k < 2; k++)
		begin
			prep(k ? ptm_pkg::MODE_LVL_HI : ptm_pkg::MODE_LVL_LO, ~k[0]);
			check("lvl supported", {7'h0, mode_supported}, 8'h01);
			run_in = 1'b1;
			wait_ev(1'b0, 8'h02);
			ext_want = k[0];
			tick(8);
			check("lvl held", count_value, 8'h00);
			check("lvl pwm held", {7'h0, pwm_drive}, 8'h01);
			ext_want = ~k[0];
			wait_ev(1'b0, 8'h03);
			wait_ev(1'b1, 8'h00);
			check("lvl keeps run", {7'h0, run_state}, 8'h01);
			check("lvl no clear", {7'h0, run_clear_pulse}, 8'h00);
			wait_ev(1'b0, 8'h02);
			run_in = 1'b0;
			tick(5);
			ext_want = k[0];
			tick(8);
			check("lvl ignored", {7'h0, count_value != 8'h00}, 8'h01);
		end
		// edge-triggered one-shot modes, slow source
		slow = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			idle = (k != 0);
			prep(ptm_pkg::MODE_OS_RISE + 5'(k), idle);
			// a halted count is kept, not cleared, until the start edge
			c = count_value;
			run_in = 1'b1;
			tick(8);
			check("os no edge", count_value, c);
			ext_want = ~idle;
			match_done();
		end
		slow = 1'b0;
		// halted edge one-shot needs a fresh edge
		prep(ptm_pkg::MODE_OS_RISE, 1'b0);
		run_in = 1'b1;
		ext_want = 1'b1;
		wait_ev(1'b0, 8'h02);
		run_in = 1'b0;
		tick(6);
		c = count_value;
		run_in = 1'b1;
		tick(8);
		check("os no resume", count_value, c);
		// edge-triggered hardware limit one-shot modes
		for (int k = 0; k < 2; k++)
		begin
			idle = k[0];
			prep(k ? ptm_pkg::MODE_HL_FALL : ptm_pkg::MODE_HL_RISE, idle);
			run_in = 1'b1;
			ext_want = ~idle;
			wait_ev(1'b0, 8'h04);
			ext_want = idle;
			tick(2);
			ext_want = ~idle;
			wait_ev(1'b0, 8'h00);
			check("hl reset run", {7'h0, run_state}, 8'h01);
			tick(5);
			check("hl pwm again", {7'h0, pwm_drive}, 8'h01);
			check("hl resumed", {7'h0, count_value != 8'h00}, 8'h01);
			match_done();
			ext_want = idle;
			tick(3);
			ext_want = ~idle;
			tick(8);
			check("hl edges ignored", count_value, 8'h00);
		end
		// level reset, edge start one-shot modes
		for (int k = 0; k < 2; k++)
		begin
			idle = k[0];
			prep(k ? ptm_pkg::MODE_LR_HI : ptm_pkg::MODE_LR_LO, ~idle);
			ext_want = idle;
			run_in = 1'b1;
			tick(8);
			check("lr held", count_value, 8'h00);
			ext_want = ~idle;
			match_done();
			ext_want = idle;
			tick(4);
			ext_want = ~idle;
			tick(8);
			check("lr needs set", count_value, 8'h00);
		end
		check("period offered", period_out, period_value);
		mode_sel = 5'h10;
		run_in = 1'b0;
		tick(4);
		check("unlisted mode", {7'h0, mode_supported}, 8'h00);
		check("unlisted pwm", {7'h0, pwm_drive}, 8'h00);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
